// file: src/level_meter_pkg.sv
// Constants shared by the level meter design
package level_meter_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_METER_CONTROL  = 8'h00;
    localparam logic [7:0] OFS_COUNT          = 8'h04;
    localparam logic [7:0] OFS_CHANNEL_CFG    = 8'h08;
    localparam logic [7:0] OFS_SHIFT_CFG      = 8'h0C;
    localparam logic [7:0] OFS_RESULT_LOW     = 8'h10;
    localparam logic [7:0] OFS_RESULT_HIGH    = 8'h14;
    localparam logic [7:0] OFS_STATUS         = 8'h18;
    localparam logic [7:0] OFS_OFFSET         = 8'h1C;
    localparam logic [7:0] OFS_COEF_RAM       = 8'h20;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    // Control register
    localparam int CTL_ENABLE      = 0;
    localparam int CTL_SINGLE      = 1;
    localparam int CTL_CHAN_LSB    = 2;
    // Channel configuration register
    localparam int CFG_AC_DC       = 0;
    localparam int CFG_DC_PATH     = 1;
    localparam int CFG_FILT_EN     = 2;
    localparam int CFG_NOTCH_BP    = 3;
    localparam int CFG_NOTCH_SRC   = 4;
    localparam int CFG_BP_SRC      = 5;
    localparam int CFG_GAIN        = 6;
    localparam int CFG_RECT        = 7;
    localparam int CFG_DC_CODE_LSB = 8;
    // Status register
    localparam int STS_DONE        = 0;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [11:0] CFG_RESET       = 12'h030;
    localparam logic [3:0]  DC_CODE_DEFAULT = 4'h0;
    localparam logic [15:0] COEF_DEFAULT    = 16'h0000;
    localparam logic [3:0]  SHIFT_MAX       = 4'hB;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int  CLK_HZ        = 100_000_000;
    localparam int  SAMPLE_HZ     = 8_000;
    localparam int  SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;
    localparam int  DONE_PULSE_US = 125;
    localparam int  DONE_CYCLES   = CLK_HZ / 1_000_000 * DONE_PULSE_US;
    localparam int  GAIN_SHIFT    = 4;
    localparam int  ACC_W         = 27;
    localparam int  COUNT_W       = 11;
    localparam int  DATA_W        = 16;
    // AHB transfer codes
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;
    // Meter states
    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_HOLD} meter_state_t;
endpackage : level_meter_pkg

// file: src/meter_filter.sv
// Notch or bandpass section on the AC meter path
module meter_filter #(
    parameter int W = 16
) (
    input  wire logic         hclk,        // System clock
    input  wire logic         hresetn,     // Async reset, low
    input  wire logic         ce,          // Clock enable
    input  wire logic         step,        // One sample strobe
    input  wire logic         enable,      // Filter in path
    input  wire logic         bandpass,    // 1 bandpass, 0 notch
    input  wire logic [W-1:0] coef,        // Centre coefficient
    input  wire logic [W-1:0] din,         // Sample in
    output logic      [W-1:0] dout         // Sample out
);
    // ------------------------------------------------------------
    // Second order resonator, Q fixed by the radius term
    // ------------------------------------------------------------
    logic signed [W+1:0]   y1_r;
    logic signed [W+1:0]   y2_r;
    logic signed [W-1:0]   x1_r;
    logic signed [W-1:0]   x2_r;
    logic signed [2*W+3:0] prod;
    logic signed [W+1:0]   res;
    logic signed [W+1:0]   bp;
    logic signed [W+1:0]   nt;
    logic signed [W+1:0]   sel;

    // Bandpass y = c*y1 - r*y2 + (x - x2)/8, r about 0.8 for Q of 5
    assign prod = y1_r * $signed({2'b00, coef});
    assign res  = (W+2)'(prod >>> (W - 2)) - (y2_r - (y2_r >>> 3) - (y2_r >>> 4))
                  + (W+2)'(($signed(din) - x2_r) >>> 3);
    assign bp   = res;
    assign nt   = (W+2)'($signed(din)) - res;
    assign sel  = bandpass ? bp : nt;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            y1_r <= '0;
            y2_r <= '0;
            x1_r <= '0;
            x2_r <= '0;
            dout <= '0;
        end else if (ce && step) begin
            y1_r <= res;
            y2_r <= y1_r;
            x1_r <= $signed(din);
            x2_r <= x1_r;
            dout <= enable ? sel[W-1:0] : din;
        end
    end
endmodule : meter_filter

// file: src/line_test_level_meter.sv
// Four-channel shared line test level meter with AHB-Lite registers
//
// Design decisions made here: register access over AHB-Lite and the register offsets.

module line_test_level_meter #(
    parameter int                 SAMPLE_DIV = level_meter_pkg::SAMPLE_CYCLES,
    parameter int                 DONE_DIV   = level_meter_pkg::DONE_CYCLES,
    parameter logic [15:0]        NOTCH_ROM  = 16'h6A3C,
    parameter logic [15:0]        BP_ROM     = 16'h6A3C
) (
    input  wire logic        hclk,              // Bus and sample clock
    input  wire logic        hresetn,           // Async reset, low
    input  wire logic        ce,                // Clock enable, freezes all state
    input  wire logic        hsel,              // Slave select
    input  wire logic [31:0] haddr,             // Byte address
    input  wire logic [1:0]  htrans,            // Transfer type
    input  wire logic        hwrite,            // Write when high
    input  wire logic [2:0]  hsize,             // Transfer size
    input  wire logic [31:0] hwdata,            // Write data
    input  wire logic        hready,            // Bus ready
    output logic      [31:0] hrdata,            // Read data
    output logic             hreadyout,         // Slave ready
    output logic             hresp,             // Always OKAY
    input  wire logic [63:0] transmit_ac_signal,// Four 16-bit AC samples
    input  wire logic [63:0] receive_dc_signal, // Four 16-bit receive DC samples
    input  wire logic [63:0] transmit_dc_pin_voltage, // Four 16-bit coded DC inputs
    output logic      [3:0]  dc_input_code,     // Coded DC input for selected channel
    output logic             integration_done_flag, // Done flag
    output logic             meter_irq          // One-cycle end pulse
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    localparam int W   = level_meter_pkg::DATA_W;
    localparam int AW  = level_meter_pkg::ACC_W;
    localparam int CW  = level_meter_pkg::COUNT_W;

    logic [1:0]            meter_channel_select_r;
    logic                  meter_enable_r;
    logic                  single_run_select_r;
    logic [CW-1:0]         integration_count_r;
    logic [11:0]           cfg_r [4];
    logic [3:0]            shift_r [4];
    logic [W-1:0]          offset_r [4];
    logic [W-1:0]          notch_ram_r;
    logic [W-1:0]          bp_ram_r;
    logic [W-1:0]          result_r;
    logic                  done_r;

    // Bus address phase capture
    logic                  wr_pend_r;
    logic [7:0]            addr_r;
    logic                  rd_pend_r;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire        valid_xfer = hsel && hready && (htrans == level_meter_pkg::HTRANS_NONSEQ
                                             || htrans == level_meter_pkg::HTRANS_SEQ);
    wire [1:0]  cs         = meter_channel_select_r;
    wire [11:0] cfg        = cfg_r[cs];
    wire        wr_ctl     = wr_pend_r && addr_r == level_meter_pkg::OFS_METER_CONTROL;
    wire        wr_cnt     = wr_pend_r && addr_r == level_meter_pkg::OFS_COUNT;
    wire        wr_cfg     = wr_pend_r && addr_r == level_meter_pkg::OFS_CHANNEL_CFG;
    wire        wr_shf     = wr_pend_r && addr_r == level_meter_pkg::OFS_SHIFT_CFG;
    wire        wr_ofs     = wr_pend_r && addr_r == level_meter_pkg::OFS_OFFSET;
    wire        wr_coef    = wr_pend_r && addr_r == level_meter_pkg::OFS_COEF_RAM;
    wire        new_en     = wr_ctl ? hwdata[level_meter_pkg::CTL_ENABLE] : meter_enable_r;

    logic [31:0] rd_mux;
    always_comb begin
        case (addr_r)
            level_meter_pkg::OFS_METER_CONTROL:
                rd_mux = {28'h0000000, meter_channel_select_r, single_run_select_r,
                          meter_enable_r};
            level_meter_pkg::OFS_COUNT:       rd_mux = {21'h00000, integration_count_r};
            level_meter_pkg::OFS_CHANNEL_CFG: rd_mux = {20'h00000, cfg};
            level_meter_pkg::OFS_SHIFT_CFG:   rd_mux = {28'h0000000, shift_r[cs]};
            level_meter_pkg::OFS_RESULT_LOW:  rd_mux = {24'h000000, result_r[7:0]};
            level_meter_pkg::OFS_RESULT_HIGH: rd_mux = {24'h000000, result_r[15:8]};
            level_meter_pkg::OFS_STATUS:      rd_mux = {31'h0000000, done_r};
            level_meter_pkg::OFS_OFFSET:      rd_mux = {16'h0000, offset_r[cs]};
            level_meter_pkg::OFS_COEF_RAM:    rd_mux = {bp_ram_r, notch_ram_r};
            default:                          rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r    <= 8'h00;
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else if (ce) begin
            wr_pend_r <= valid_xfer && hwrite;
            rd_pend_r <= valid_xfer && !hwrite;
            hreadyout <= !(valid_xfer && !hwrite);
            if (valid_xfer) begin
                addr_r <= haddr[7:0];
            end
            if (rd_pend_r) begin
                hrdata <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meter_channel_select_r <= 2'h0;
            meter_enable_r         <= 1'b0;
            single_run_select_r    <= 1'b0;
            integration_count_r    <= '0;
            notch_ram_r            <= level_meter_pkg::COEF_DEFAULT;
            bp_ram_r               <= level_meter_pkg::COEF_DEFAULT;
            for (int i = 0; i < 4; i++) begin
                cfg_r[i]    <= level_meter_pkg::CFG_RESET;
                shift_r[i]  <= 4'h0;
                offset_r[i] <= '0;
            end
        end else if (ce) begin
            meter_enable_r <= new_en;
            if (wr_ctl) begin
                single_run_select_r    <= hwdata[level_meter_pkg::CTL_SINGLE];
                meter_channel_select_r <= hwdata[level_meter_pkg::CTL_CHAN_LSB +: 2];
            end
            if (wr_cnt) begin
                integration_count_r <= hwdata[CW-1:0];
            end
            if (wr_cfg) begin
                cfg_r[cs] <= hwdata[11:0];
            end
            if (wr_shf) begin
                shift_r[cs] <= hwdata[3:0];
            end
            if (wr_ofs) begin
                offset_r[cs] <= hwdata[W-1:0];
            end
            if (wr_coef) begin
                notch_ram_r <= hwdata[15:0];
                bp_ram_r    <= hwdata[31:16];
            end
        end
    end

    // ------------------------------------------------------------
    // Sample strobe at 8 kHz
    // ------------------------------------------------------------
    logic [$clog2(SAMPLE_DIV)-1:0] div_r;
    wire step = (div_r == '0);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_r <= '0;
        end else if (ce) begin
            div_r <= step ? ($clog2(SAMPLE_DIV))'(SAMPLE_DIV - 1) : div_r - 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Source, filter, gain and rectifier
    // ------------------------------------------------------------
    wire        ac_sel    = cfg[level_meter_pkg::CFG_AC_DC];
    wire        dc_path   = cfg[level_meter_pkg::CFG_DC_PATH];
    wire        filt_en   = cfg[level_meter_pkg::CFG_FILT_EN];
    wire        bp_sel    = cfg[level_meter_pkg::CFG_NOTCH_BP];
    wire        n_rom     = cfg[level_meter_pkg::CFG_NOTCH_SRC];
    wire        b_rom     = cfg[level_meter_pkg::CFG_BP_SRC];
    wire        gain_on   = cfg[level_meter_pkg::CFG_GAIN];
    wire        rect_on   = cfg[level_meter_pkg::CFG_RECT];
    wire [W-1:0] ac_in    = transmit_ac_signal[cs*W +: W];
    wire [W-1:0] rx_dc    = receive_dc_signal[cs*W +: W];
    wire [W-1:0] tx_dc    = transmit_dc_pin_voltage[cs*W +: W] - offset_r[cs];
    wire [W-1:0] notch_c  = n_rom ? NOTCH_ROM : notch_ram_r;
    wire [W-1:0] bp_c     = b_rom ? BP_ROM : bp_ram_r;
    wire [W-1:0] coef     = bp_sel ? bp_c : notch_c;
    wire [W-1:0] ac_filt;
    wire [W-1:0] dc_sig   = dc_path ? tx_dc : rx_dc;
    wire [W-1:0] src      = ac_sel ? ac_filt : dc_sig;
    wire signed [W+3:0] gained = gain_on ? ($signed(src) <<< level_meter_pkg::GAIN_SHIFT)
                                         : (W+4)'($signed(src));
    wire signed [W+3:0] rect   = (rect_on && gained < 0) ? -gained : gained;

    meter_filter #(
        .W        (W)
    ) u_filter (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .ce       (ce),
        .step     (step),
        .enable   (filt_en),
        .bandpass (bp_sel),
        .coef     (coef),
        .din      (ac_in),
        .dout     (ac_filt)
    );

    // ------------------------------------------------------------
    // Integrator
    // ------------------------------------------------------------
    level_meter_pkg::meter_state_t state_r;
    logic signed [AW-1:0]          acc_r;
    logic [CW-1:0]                 cnt_r;
    logic [$clog2(DONE_DIV+1)-1:0] done_cnt_r;
    logic                          en_d_r;
    logic                          irq_r;

    wire [3:0]            shift   = (shift_r[cs] > level_meter_pkg::SHIFT_MAX)
                                  ? level_meter_pkg::SHIFT_MAX : shift_r[cs];
    wire signed [AW-1:0]  acc_sum = acc_r + AW'(rect);
    wire signed [AW-1:0]  scaled  = acc_sum >>> shift;
    wire                  rise    = meter_enable_r && !en_d_r;
    wire                  last    = step && cnt_r == integration_count_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r    <= level_meter_pkg::ST_IDLE;
            acc_r      <= '0;
            cnt_r      <= '0;
            done_r     <= 1'b0;
            done_cnt_r <= '0;
            en_d_r     <= 1'b0;
            irq_r      <= 1'b0;
            result_r   <= '0;
        end else if (ce) begin
            en_d_r <= meter_enable_r;
            irq_r  <= 1'b0;
            if (done_cnt_r != '0) begin
                done_cnt_r <= done_cnt_r - 1'b1;
                if (done_cnt_r == 1 && !single_run_select_r) begin
                    done_r <= 1'b0;
                end
            end
            case (state_r)
                level_meter_pkg::ST_IDLE: begin
                    done_r <= 1'b0;
                    if (rise) begin
                        state_r <= level_meter_pkg::ST_RUN;
                        acc_r   <= '0;
                        cnt_r   <= '0;
                    end
                end
                level_meter_pkg::ST_RUN: begin
                    if (!meter_enable_r) begin
                        state_r <= level_meter_pkg::ST_IDLE;
                    end else if (step) begin
                        acc_r <= acc_sum;
                        cnt_r <= cnt_r + 1'b1;
                        if (last) begin
                            result_r   <= scaled[W-1:0];
                            done_r     <= 1'b1;
                            irq_r      <= 1'b1;
                            done_cnt_r <= ($clog2(DONE_DIV+1))'(DONE_DIV);
                            acc_r      <= '0;
                            cnt_r      <= '0;
                            if (single_run_select_r) begin
                                state_r <= level_meter_pkg::ST_HOLD;
                            end
                        end
                    end
                end
                level_meter_pkg::ST_HOLD: begin
                    if (!meter_enable_r) begin
                        done_r  <= 1'b0;
                        state_r <= level_meter_pkg::ST_IDLE;
                    end
                end
                default: state_r <= level_meter_pkg::ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dc_input_code         <= level_meter_pkg::DC_CODE_DEFAULT;
            integration_done_flag <= 1'b0;
            meter_irq             <= 1'b0;
        end else if (ce) begin
            dc_input_code         <= cfg[level_meter_pkg::CFG_DC_CODE_LSB +: 4];
            integration_done_flag <= done_r;
            meter_irq             <= irq_r;
        end
    end
endmodule : line_test_level_meter

// file: verification/line_test_level_meter_asserts.sv
// Port timing checks for the line test level meter
module line_test_level_meter_asserts #(
    parameter int SAMPLE_DIV = 8
) (
    input wire logic        hclk,                  // Clock
    input wire logic        hresetn,               // Async reset, low
    input wire logic        hsel,                  // Slave select
    input wire logic [1:0]  htrans,                // Transfer type
    input wire logic        hwrite,                // Write when high
    input wire logic        hready,                // Bus ready
    input wire logic [31:0] hrdata,                // Read data
    input wire logic        hreadyout,             // Slave ready
    input wire logic        hresp,                 // Response
    input wire logic        integration_done_flag, // Done flag
    input wire logic        meter_irq              // End pulse
);
    // ------------------------------------------------------------
    // Cycles since the last end pulse
    // ------------------------------------------------------------
    int gap_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            gap_r <= 0;
        else
            gap_r <= meter_irq ? 0 : gap_r + 1;
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("error response seen");
    a_read_one_wait: assert property (hsel && hready && htrans[1] && !hwrite
        |=> !hreadyout ##1 hreadyout) else $error("read wait state wrong");
    a_write_no_wait: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
        else $error("write stalled");
    a_rdata_holds: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
        else $error("read data changed outside a read");
    a_irq_one_cycle: assert property (meter_irq |=> !meter_irq)
        else $error("end pulse longer than one cycle");
    a_irq_sample_gap: assert property (meter_irq |-> gap_r >= SAMPLE_DIV - 1)
        else $error("integrations closer than one sample");
    a_irq_sets_done: assert property (meter_irq |-> ##[0:2] integration_done_flag)
        else $error("done flag missing after end pulse");
    a_done_has_cause: assert property ($rose(integration_done_flag)
        |-> meter_irq || $past(meter_irq) || $past(meter_irq, 2))
        else $error("done flag set without end pulse");
endmodule : line_test_level_meter_asserts

bind line_test_level_meter line_test_level_meter_asserts #(.SAMPLE_DIV(SAMPLE_DIV)) chk_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .integration_done_flag(integration_done_flag), .meter_irq(meter_irq));

// file: verification/tb_top.sv
// Self-checking bench for the line test level meter
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, rdy, resp, done, irq;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
    logic [63:0] ac = '0, rx = '0, tx = '0;
    logic [3:0]  code;
    int          miscompares = 0, num_checks = 0, cyc = 0;
    line_test_level_meter #(.SAMPLE_DIV(8), .DONE_DIV(4)) dut_u (.hclk(hclk),
        .hresetn(hresetn), .ce(1'b1), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(rdy), .hrdata(hrdata),
        .hreadyout(rdy), .hresp(resp), .transmit_ac_signal(ac), .receive_dc_signal(rx),
        .transmit_dc_pin_voltage(tx), .dc_input_code(code),
        .integration_done_flag(done), .meter_irq(irq));
    always #5 hclk = ~hclk;
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic report_and_stop;
        if (miscompares == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            report_and_stop();
        end
    end
    task automatic check(input logic [31:0] s, input logic [31:0] e, input string m);
        num_checks++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, m, s, e);
        end
    endtask : check
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (rdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (rdy !== 1'b1);
        q = hrdata;
    endtask : bus
    task automatic wait_done(input logic v, input int lim);
        for (int n = 0; n < lim && done !== v; n++) @(posedge hclk);
        check(done, v, "done flag");
    endtask : wait_done
    task automatic count_irq(input int len, output int n);
        n = 0;
        repeat (len) begin
            @(posedge hclk);
            n += int'(irq === 1'b1);
        end
    endtask : count_irq
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        logic [31:0] r;
        check(code, 4'h0, "code at reset");
        bus(0, 8'h08, 0);
        check(q, 32'h030, "cfg reset");
        bus(0, 8'h40, 0);
        check(q, 0, "unmapped read");
        bus(0, 8'h10, 0);
        r = q;
        bus(1, 8'h10, 32'hFF);
        bus(0, 8'h10, 0);
        check(q, r, "result written by bus");
    endtask : t_reset
    task automatic t_paths;
        logic [11:0] cf [7] = '{12'h031, 12'h071, 12'h0B1, 12'h0F1, 12'h071, 12'h030, 12'hE32};
        logic [3:0]  sh [7] = '{4'h0, 4'h0, 4'h0, 4'h2, 4'hF, 4'h0, 4'h0};
        logic [15:0] vv [7] = '{16'h0123, 16'hFF00, 16'hFF00, 16'hFF00, 16'h0400, 16'h50, 16'h50};
        logic [63:0] s;
        int          e, n;
        for (int i = 0; i < 7; i++) begin
            bus(1, 8'h00, 32'h8);
            bus(1, 8'h04, 32'h3);
            bus(1, 8'h08, {20'h0, cf[i]});
            bus(1, 8'h0C, {28'h0, sh[i]});
            bus(1, 8'h1C, (i == 6) ? 32'h10 : 32'h0);
            bus(0, 8'h08, 0);
            check(q, {20'h0, cf[i]}, "cfg readback");
            check(code, cf[i][11:8], "dc code");
            s = {16'h1111, vv[i], 32'h11111111};
            ac <= cf[i][0] ? s : {4{16'h1111}};
            rx <= (cf[i][1:0] == 2'b00) ? s : {4{16'h1111}};
            tx <= (cf[i][1:0] == 2'b10) ? s : {4{16'h1111}};
            repeat (20) @(posedge hclk);
            bus(1, 8'h00, 32'hB);
            wait_done(1'b1, 200);
            e = $signed(vv[i]) - ((i == 6) ? 16 : 0);
            e = cf[i][6] ? e * 16 : e;
            e = (cf[i][7] && e < 0) ? -e : e;
            e = (e * 4) >>> ((sh[i] > 4'hA) ? 11 : sh[i]);
            bus(0, 8'h10, 0);
            check(q, e[7:0], "result low");
            bus(0, 8'h14, 0);
            check(q, e[15:8], "result high");
            count_irq(30, n);
            check(n, 0, "extra run");
            check(done, 1'b1, "done held");
            bus(1, 8'h00, 32'h8);
            wait_done(1'b0, 10);
        end
    endtask : t_paths
    task automatic t_cont;
        int n;
        bus(1, 8'h04, 32'h1);
        bus(1, 8'h08, 32'h031);
        bus(1, 8'h00, 32'h9);
        wait_done(1'b1, 200);
        for (n = 0; n < 20 && done === 1'b1; n++) @(posedge hclk);
        check(n >= 3 && n <= 5, 1, "done width");
        count_irq(64, n);
        check(n, 4, "continuous runs");
        bus(1, 8'h00, 32'h8);
        repeat (4) @(posedge hclk);
        count_irq(40, n);
        check(n, 0, "runs after stop");
    endtask : t_cont
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_paths();
        t_cont();
        report_and_stop();
    end
endmodule : tb_top
